// ===== dawc_map.svh
// Register offsets, field positions, reset values and timing counts of the wrap control block
`ifndef DAWC_MAP_SVH
`define DAWC_MAP_SVH
`define DAWC_OFF_CTRL 8'h00
`define DAWC_OFF_SRC_INIT 8'h04
`define DAWC_OFF_DST_INIT 8'h08
`define DAWC_OFF_LENGTH 8'h0C
`define DAWC_OFF_CUR_SRC 8'h14
`define DAWC_OFF_CUR_DST 8'h18
`define DAWC_OFF_CUR_CNT 8'h1C
`define DAWC_OFF_IRQ_MASK 8'h20
`define DAWC_OFF_IRQ_STAT 8'h24
`define DAWC_OFF_GATE 8'h28
`define DAWC_CTRL_RESET 32'h0000_0000
`define DAWC_CTRL_WMASK 32'h0018_F0F0
`define DAWC_WIS_HALF 14
`define DAWC_WIS_FULL 12
`define DAWC_DAM_LSB 6
`define DAWC_SAM_LSB 4
`define DAWC_USS_LSB 19
`define DAWC_MODE_INC 2'b00
`define DAWC_MODE_FIX 2'b10
`define DAWC_MODE_WRAP 2'b11
`define DAWC_USS_WORD 2'b00
`define DAWC_USS_BYTE 2'b01
`define DAWC_USS_HALF 2'b10
`define DAWC_IRQ_HALF 0
`define DAWC_IRQ_FULL 1
`define DAWC_IRQ_DONE 2
`define DAWC_UNIT_CYCLES 2
`endif

// ===== dawc_pkg.sv
// Types shared by the wrap control block
package dawc_pkg;
  typedef enum logic [1:0] {DAWC_IDLE, DAWC_READ, DAWC_WRITE} dawc_state_e;
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] cnt;
  } dawc_ptrs_s;
endpackage

// ===== dawc_ptr_step.sv
// Next pointer value for one address mode
`timescale 1ns/10ps
`include "dawc_map.svh"
module dawc_ptr_step
  import dawc_pkg::*;
(
  input wire logic [31:0] i_ptr,
  input wire logic [31:0] i_init,
  input wire logic [1:0] i_mode,
  input wire logic [2:0] i_step,
  input wire logic i_wrap,
  output logic [31:0] o_next
);
  always_comb begin
    case (i_mode)
      `DAWC_MODE_INC: o_next = i_ptr + {29'h0000_0000, i_step};
      `DAWC_MODE_FIX: o_next = i_ptr;
      `DAWC_MODE_WRAP: o_next = i_wrap ? i_init : i_ptr + {29'h0000_0000, i_step};
      default: o_next = i_ptr;
    endcase
  end
endmodule // dawc_ptr_step

// ===== dawc_top.sv
// Address wrap control and wrap interrupts of one DMA channel
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "dawc_map.svh"
module dawc_top
  import dawc_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_START,
  output logic O_BUSY,
  output logic O_RD_STB,
  output logic O_WR_STB,
  output logic [31:0] O_SRC_ADDR,
  output logic [31:0] O_DST_ADDR,
  output logic O_IRQ
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] src_init;
    logic [31:0] dst_init;
    logic [31:0] length;
    logic [2:0] mask;
    logic [2:0] stat;
    logic gate;
    dawc_ptrs_s cur;
    dawc_state_e state;
    logic half_done;
    logic staged;
    logic [31:0] rdat;
    logic ack;
    logic rd_stb;
    logic wr_stb;
    logic irq;
    logic busy;
  } dawc_regs_s;

  dawc_regs_s r;
  dawc_regs_s next_r;
  logic [2:0] step;
  logic wrap_any;
  logic unit_last;
  logic [31:0] next_src;
  logic [31:0] next_dst;
  logic [1:0] dam;
  logic [1:0] sam;
  logic [1:0] uss;
  logic wb_req;
  logic [2:0] events;
  logic [31:0] rd_mux;
  logic [31:0] ctrl_wmask;
  logic [31:0] cnt_after;

  assign dam = r.ctrl[`DAWC_DAM_LSB +: 2];
  assign sam = r.ctrl[`DAWC_SAM_LSB +: 2];
  assign uss = r.ctrl[`DAWC_USS_LSB +: 2];
  assign wrap_any = (dam == `DAWC_MODE_WRAP) || (sam == `DAWC_MODE_WRAP);
  assign wb_req = I_WB_CYC && I_WB_STB && !r.ack;
  // Sliced per byte lane so that reserved control bits stay zero, except unused bits 13 and 15, which the mask passes
  assign ctrl_wmask = `DAWC_CTRL_WMASK;

  always_comb begin
    case (uss)
      `DAWC_USS_BYTE: step = 3'h1;
      `DAWC_USS_HALF: step = 3'h2;
      default: step = 3'h4;
    endcase
  end

  // Last unit when the remaining count would reach zero
  assign unit_last = (r.cur.cnt <= {29'h0000_0000, step});
  // A short last unit ends at zero rather than wrapping the count below it
  assign cnt_after = unit_last ? 32'h0000_0000 : r.cur.cnt - {29'h0000_0000, step};

  dawc_ptr_step u_src (
    .i_ptr(r.cur.src),
    .i_init(r.src_init),
    .i_mode(sam),
    .i_step(step),
    .i_wrap(unit_last),
    .o_next(next_src)
  );

  dawc_ptr_step u_dst (
    .i_ptr(r.cur.dst),
    .i_init(r.dst_init),
    .i_mode(dam),
    .i_step(step),
    .i_wrap(unit_last),
    .o_next(next_dst)
  );

  always_comb begin
    case (I_WB_ADR)
      `DAWC_OFF_CTRL: rd_mux = r.ctrl;
      `DAWC_OFF_SRC_INIT: rd_mux = r.src_init;
      `DAWC_OFF_DST_INIT: rd_mux = r.dst_init;
      `DAWC_OFF_LENGTH: rd_mux = r.length;
      `DAWC_OFF_CUR_SRC: rd_mux = r.cur.src;
      `DAWC_OFF_CUR_DST: rd_mux = r.cur.dst;
      `DAWC_OFF_CUR_CNT: rd_mux = r.cur.cnt;
      `DAWC_OFF_IRQ_MASK: rd_mux = {29'h0000_0000, r.mask};
      `DAWC_OFF_IRQ_STAT: rd_mux = {29'h0000_0000, r.stat};
      `DAWC_OFF_GATE: rd_mux = {31'h0000_0000, r.gate};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_r = r;
    events = 3'b000;
    next_r.ack = wb_req;
    next_r.rd_stb = 1'b0;
    next_r.wr_stb = 1'b0;
    if (wb_req) begin
      next_r.rdat = rd_mux;
    end
    if (wb_req && I_WB_WE) begin
      for (int b = 0; b < 4; b++) begin
        if (I_WB_SEL[b]) begin
          case (I_WB_ADR)
            `DAWC_OFF_CTRL: next_r.ctrl[8*b +: 8] =
                I_WB_DAT[8*b +: 8] & ctrl_wmask[8*b +: 8];
            `DAWC_OFF_SRC_INIT: next_r.src_init[8*b +: 8] = I_WB_DAT[8*b +: 8];
            `DAWC_OFF_DST_INIT: next_r.dst_init[8*b +: 8] = I_WB_DAT[8*b +: 8];
            `DAWC_OFF_LENGTH: next_r.length[8*b +: 8] = I_WB_DAT[8*b +: 8];
            default: begin
            end
          endcase
        end
      end
      if (I_WB_SEL[0]) begin
        if (I_WB_ADR == `DAWC_OFF_IRQ_MASK) begin
          next_r.mask = I_WB_DAT[2:0];
        end
        if (I_WB_ADR == `DAWC_OFF_GATE) begin
          next_r.gate = I_WB_DAT[0];
        end
      end
    end

    case (r.state)
      DAWC_IDLE: begin
        if (I_START && r.gate && r.length != 32'h0000_0000) begin
          next_r.cur.src = r.src_init;
          next_r.cur.dst = r.dst_init;
          next_r.cur.cnt = r.length;
          next_r.half_done = 1'b0;
          next_r.state = DAWC_READ;
          next_r.rd_stb = 1'b1;
        end
      end
      DAWC_READ: begin
        // Unit data now sits in the staging buffer
        next_r.staged = 1'b1;
        if (!r.gate) begin
          next_r.staged = 1'b0;
          next_r.state = DAWC_IDLE;
        end else begin
          next_r.state = DAWC_WRITE;
          next_r.wr_stb = 1'b1;
        end
      end
      DAWC_WRITE: begin
        // The unit already on the bus completes even if the gate drops
        next_r.staged = 1'b0;
        next_r.cur.src = next_src;
        next_r.cur.dst = next_dst;
        next_r.cur.cnt = cnt_after;
        if (wrap_any && r.ctrl[`DAWC_WIS_HALF] && !r.half_done &&
            cnt_after <= {1'b0, r.length[31:1]}) begin
          events[`DAWC_IRQ_HALF] = 1'b1;
          next_r.half_done = 1'b1;
        end
        if (unit_last) begin
          if (wrap_any) begin
            next_r.cur.cnt = r.length;
            next_r.half_done = 1'b0;
            events[`DAWC_IRQ_FULL] = r.ctrl[`DAWC_WIS_FULL];
            next_r.state = r.gate ? DAWC_READ : DAWC_IDLE;
            next_r.rd_stb = r.gate;
          end else begin
            next_r.cur.cnt = 32'h0000_0000;
            events[`DAWC_IRQ_DONE] = 1'b1;
            next_r.state = DAWC_IDLE;
          end
        end else begin
          next_r.state = r.gate ? DAWC_READ : DAWC_IDLE;
          next_r.rd_stb = r.gate;
        end
      end
      default: next_r.state = DAWC_IDLE;
    endcase

    // Read of status clears it, but a same-cycle event survives
    if (wb_req && !I_WB_WE && I_WB_ADR == `DAWC_OFF_IRQ_STAT) begin
      next_r.stat = 3'b000;
    end
    next_r.stat = next_r.stat | events;
    next_r.irq = |(next_r.stat & next_r.mask);
    // Busy kept in a flop so the pin never decodes state on the fly
    next_r.busy = (next_r.state != DAWC_IDLE);
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign O_WB_DAT = r.rdat;
  assign O_WB_ACK = r.ack;
  assign O_BUSY = r.busy;
  assign O_RD_STB = r.rd_stb;
  assign O_WR_STB = r.wr_stb;
  assign O_SRC_ADDR = r.cur.src;
  assign O_DST_ADDR = r.cur.dst;
  assign O_IRQ = r.irq;

  // Unit phases that the checks below are built from
  sequence seq_mid_unit;
    r.state == DAWC_WRITE && !unit_last;
  endsequence
  sequence seq_wrap_point;
    r.state == DAWC_WRITE && unit_last && wrap_any;
  endsequence
  sequence seq_wrap_go;
    r.state == DAWC_WRITE && unit_last && wrap_any && r.gate;
  endsequence
  sequence seq_restart;
    r.state == DAWC_READ && r.rd_stb;
  endsequence

  AST_FULL_IRQ: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && unit_last && wrap_any && r.ctrl[`DAWC_WIS_FULL])
    |=> r.stat[`DAWC_IRQ_FULL])
    else $error("full wrap event not recorded");
  AST_HALF_NEEDS_WRAP: assert property (@(posedge I_CLK) disable iff (I_RST)
    (events[`DAWC_IRQ_HALF]) |-> (wrap_any && r.ctrl[`DAWC_WIS_HALF]))
    else $error("half event outside wrap mode");
  AST_BOTH: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && unit_last && wrap_any && r.ctrl[`DAWC_WIS_FULL]
     && r.ctrl[`DAWC_WIS_HALF] && !r.half_done) |=> (&r.stat[1:0]))
    else $error("half and full not both raised");
  AST_DST_INC: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && dam == `DAWC_MODE_INC && !wb_req)
    |=> r.cur.dst == $past(r.cur.dst) + {29'h0000_0000, $past(step)})
    else $error("destination did not increment");
  AST_DST_FIX: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && dam == `DAWC_MODE_FIX) |=> $stable(r.cur.dst))
    else $error("fixed destination moved");
  AST_WRAP_RELOAD: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && unit_last && dam == `DAWC_MODE_WRAP)
    |=> (r.cur.dst == $past(r.dst_init) && r.cur.cnt == $past(r.length)))
    else $error("destination wrap reload wrong");
  AST_RESTART: assert property (@(posedge I_CLK) disable iff (I_RST)
    seq_wrap_go |=> seq_restart)
    else $error("wrap did not restart");
  AST_GATE_DROP: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_READ && !r.gate) |=> (r.state == DAWC_IDLE && !r.wr_stb))
    else $error("staged data written after gate off");
  AST_SRC_FIX: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && sam == `DAWC_MODE_FIX) |=> $stable(r.cur.src))
    else $error("fixed source moved");
  AST_SRC_WRAP: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && unit_last && sam == `DAWC_MODE_WRAP)
    |=> r.cur.src == $past(r.src_init))
    else $error("source wrap reload wrong");
  AST_BYTE_STEP: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && uss == `DAWC_USS_BYTE && !unit_last)
    |=> r.cur.cnt == $past(r.cur.cnt) - 32'h0000_0001)
    else $error("byte unit count step wrong");

  // Stepping, reload and restart of the pointers
  AST_SRC_INC: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && sam == `DAWC_MODE_INC)
    |=> r.cur.src == $past(r.cur.src) + {29'h0000_0000, $past(step)})
    else $error("source did not increment");
  AST_CNT_STEP: assert property (@(posedge I_CLK) disable iff (I_RST)
    seq_mid_unit |=> r.cur.cnt == $past(r.cur.cnt) - {29'h0000_0000, $past(step)})
    else $error("count did not step by unit size");
  AST_WORD_STEP: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && uss == `DAWC_USS_WORD && !unit_last)
    |=> r.cur.cnt == $past(r.cur.cnt) - 32'h0000_0004)
    else $error("word unit count step wrong");
  AST_HALF_STEP: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && uss == `DAWC_USS_HALF && !unit_last)
    |=> r.cur.cnt == $past(r.cur.cnt) - 32'h0000_0002)
    else $error("half-word unit count step wrong");
  AST_WRAP_CNT: assert property (@(posedge I_CLK) disable iff (I_RST)
    seq_wrap_point |=> r.cur.cnt == $past(r.length))
    else $error("wrap count reload wrong");
  AST_NEW_PASS: assert property (@(posedge I_CLK) disable iff (I_RST)
    seq_wrap_go ##1 r.gate |=> (r.state == DAWC_WRITE && r.wr_stb && r.staged))
    else $error("restarted pass did not write its first unit");
  AST_START_LOAD: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_IDLE && I_START && r.gate && r.length != 32'h0000_0000)
    |=> (r.state == DAWC_READ && r.rd_stb && r.cur.src == $past(r.src_init)
         && r.cur.dst == $past(r.dst_init) && r.cur.cnt == $past(r.length)))
    else $error("start did not load the pointers");
  AST_DONE_END: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && unit_last && !wrap_any)
    |=> (r.stat[`DAWC_IRQ_DONE] && r.state == DAWC_IDLE && r.cur.cnt == 32'h0000_0000))
    else $error("plain transfer did not end cleanly");

  // Interrupt events, the staging buffer and the stop when the gate is off
  AST_HALF_FIRES: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && wrap_any && r.ctrl[`DAWC_WIS_HALF] && !r.half_done
     && (unit_last || r.cur.cnt <= {1'b0, r.length[31:1]} + {29'h0000_0000, step}))
    |=> r.stat[`DAWC_IRQ_HALF])
    else $error("half-way wrap event missed");
  AST_STAGED_WRITE: assert property (@(posedge I_CLK) disable iff (I_RST)
    r.wr_stb |-> r.staged)
    else $error("write strobe without staged data");
  AST_GATE_STOP: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_WRITE && !r.gate) |=> (r.state == DAWC_IDLE && !r.rd_stb))
    else $error("channel kept cycling with gate off");
  AST_IDLE_QUIET: assert property (@(posedge I_CLK) disable iff (I_RST)
    (r.state == DAWC_IDLE) |-> (!r.wr_stb && !r.staged))
    else $error("idle channel still holds or writes data");
endmodule // dawc_top

// ===== dawc_bus_model.sv
// Bus slave stand-in that tallies the channel's unit strobes and addresses
`timescale 1ns/10ps
module dawc_bus_model (
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic i_rd_stb,
  input wire logic i_wr_stb,
  input wire logic [31:0] i_src_addr,
  input wire logic [31:0] i_dst_addr,
  output logic [31:0] o_nrd,
  output logic [31:0] o_nwr,
  output logic [31:0] o_mrd,
  output logic [31:0] o_mwr
);
  // Slaves answer at once; highest address kept to see where wrapping folds back
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      o_nrd <= 32'h0000_0000;
      o_nwr <= 32'h0000_0000;
      o_mrd <= 32'h0000_0000;
      o_mwr <= 32'h0000_0000;
    end else begin
      if (i_rd_stb) begin
        o_nrd <= o_nrd + 32'h0000_0001;
        if (i_src_addr > o_mrd) o_mrd <= i_src_addr;
      end
      if (i_wr_stb) begin
        o_nwr <= o_nwr + 32'h0000_0001;
        if (i_dst_addr > o_mwr) o_mwr <= i_dst_addr;
      end
    end
  end
endmodule // dawc_bus_model

// ===== tb_dma_channel_address_wrap_control.sv
// Testbench of the wrap control block
`timescale 1ns/10ps
`include "dawc_map.svh"
module tb_dma_channel_address_wrap_control;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, start = 0, clr = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0000_0000, q, wb_q, src_a, dst_a, nrd, nwr, mrd, mwr;
  logic ack, busy, rds, wrs, irq;
  int err_total = 0, n_checks = 0, cyc_cnt = 0, k;
  logic [31:0] ctl [4] = '{32'h0000_0000, 32'h0008_00A0, 32'h0010_0080, 32'h0008_0020};
  logic [31:0] len [4] = '{32'h0000_0008, 32'h0000_0003, 32'h0000_0004, 32'h0000_0002};
  logic [31:0] es [4] = '{32'h0000_0108, 32'h0000_0100, 32'h0000_0104, 32'h0000_0100};
  logic [31:0] ed [4] = '{32'h0000_0208, 32'h0000_0200, 32'h0000_0200, 32'h0000_0202};
  logic [31:0] nu [4] = '{32'h0000_0002, 32'h0000_0003, 32'h0000_0002, 32'h0000_0002};
  logic [31:0] wctl [5] = '{32'h0000_40C0, 32'h0000_10C0, 32'h0000_50C0, 32'h0000_5030,
    32'h0000_50C0};
  logic [31:0] wexp [5] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0003, 32'h0000_0003,
    32'h0000_0003};
  // The last pass is one unit long, so half and full fire on the same edge
  logic [31:0] wlen [5] = '{32'h0000_0008, 32'h0000_0008, 32'h0000_0008, 32'h0000_0008,
    32'h0000_0004};
  always #5 clk = ~clk;
  dawc_top dawc_top_inst (.I_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(wb_q),
    .O_WB_ACK(ack), .I_START(start), .O_BUSY(busy), .O_RD_STB(rds), .O_WR_STB(wrs),
    .O_SRC_ADDR(src_a), .O_DST_ADDR(dst_a), .O_IRQ(irq));
  dawc_bus_model dawc_bus_model_inst (.i_clk(clk), .i_clr(clr), .i_rd_stb(rds),
    .i_wr_stb(wrs), .i_src_addr(src_a), .i_dst_addr(dst_a), .o_nrd(nrd), .o_nwr(nwr),
    .o_mrd(mrd), .o_mwr(mwr));
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = wb_q;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  // Partner tallies are cleared on the start edge, before the first strobe
  task go;
    @(posedge clk) begin start <= 1; clr <= 1; end
    @(posedge clk) begin start <= 0; clr <= 0; end
  endtask
  // Busy only rises after the start edge has landed
  task idle;
    @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_total++;
      stop_test;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    rd(`DAWC_OFF_CTRL, `DAWC_CTRL_RESET);
    wb(1, `DAWC_OFF_CTRL, 32'hFFFF_FFFF);
    rd(`DAWC_OFF_CTRL, `DAWC_CTRL_WMASK);
    rd(8'h30, 32'h0000_0000);
    wb(1, `DAWC_OFF_SRC_INIT, 32'h0000_0100);
    wb(1, `DAWC_OFF_DST_INIT, 32'h0000_0200);
    wb(1, `DAWC_OFF_LENGTH, 32'h0000_0008);
    wb(1, `DAWC_OFF_GATE, 32'h0000_0000);
    go;
    repeat (2) @(posedge clk);
    chk(busy, 0);
    $display("test registers done");
    wb(1, `DAWC_OFF_IRQ_MASK, 32'h0000_0004);
    for (k = 0; k < 4; k++) begin
      wb(1, `DAWC_OFF_CTRL, ctl[k]);
      wb(1, `DAWC_OFF_LENGTH, len[k]);
      wb(1, `DAWC_OFF_GATE, 32'h0000_0001);
      go;
      idle;
      rd(`DAWC_OFF_CUR_SRC, es[k]);
      rd(`DAWC_OFF_CUR_DST, ed[k]);
      rd(`DAWC_OFF_CUR_CNT, 32'h0000_0000);
      chk(nrd, nu[k]);
      chk(nwr, nu[k]);
      chk(irq, 1);
      rd(`DAWC_OFF_IRQ_STAT, 32'h0000_0004);
      repeat (2) @(posedge clk);
      chk(irq, 0);
    end
    $display("test address modes done");
    wb(1, `DAWC_OFF_IRQ_MASK, 32'h0000_0003);
    for (k = 0; k < 5; k++) begin
      wb(0, `DAWC_OFF_IRQ_STAT, 32'h0000_0000);
      wb(1, `DAWC_OFF_CTRL, wctl[k]);
      wb(1, `DAWC_OFF_LENGTH, wlen[k]);
      wb(1, `DAWC_OFF_GATE, 32'h0000_0001);
      go;
      // Varying the wait lands the gate clear in both the read and the write phase
      repeat (40 + k) @(posedge clk);
      chk(busy, 1);
      chk(irq, 1);
      wb(1, `DAWC_OFF_GATE, 32'h0000_0000);
      idle;
      chk(nrd - nwr <= 1, 1);
      chk(nwr > 3, 1);
      chk((wctl[k][7:6] == 2'b11 ? mwr - 32'h0000_0200 : mrd - 32'h0000_0100) < 8, 1);
      wb(0, `DAWC_OFF_IRQ_STAT, 32'h0000_0000);
      chk(q & 32'h0000_0003, wexp[k]);
    end
    $display("test wrap done");
    stop_test;
  end
endmodule // tb_dma_channel_address_wrap_control
